// File: sbc_regs.svh
// register offsets, field positions, reset values and timing counts of the serial bus control block
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// register byte offsets on the apb bus
`define SBC_OFF_CTRL   12'h000
`define SBC_OFF_DATA   12'h004
`define SBC_OFF_STAT   12'h008
`define SBC_OFF_MASK   12'h00C

// serial_bus_control_b field positions
`define SBC_B_ROLE     7
`define SBC_B_DIR      6
`define SBC_B_BUSY     5
`define SBC_B_CANCEL   4
`define SBC_B_MODE_HI  3
`define SBC_B_MODE_LO  2
`define SBC_B_SRST_HI  1
`define SBC_B_SRST_LO  0

// reset values
`define SBC_CTRL_RST   8'h10
`define SBC_MODE_RST   2'h0
`define SBC_SRST_RST   2'h0
`define SBC_BYTE_RST   8'h00
`define SBC_EV_RST     3'h0

// operating modes
`define SBC_MODE_PORT  2'h0
`define SBC_MODE_SIO   2'h1

// event bits of the status and mask registers
`define SBC_EV_W       3
`define SBC_EV_XFER    0
`define SBC_EV_START   1
`define SBC_EV_STOP    2

// timing: half period of a generated serial clock, least time, rounded up
`define SBC_CLK_NS     8
`define SBC_HALF_NS    64
`define SBC_HALF_CYC   ((`SBC_HALF_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_DIV_W      4
`define SBC_DIV_LAST   (`SBC_DIV_W'(`SBC_HALF_CYC - 1))
`define SBC_DIV_ZERO   4'h0

// bits per serial unit
`define SBC_CNT_W      4
`define SBC_CNT_ZERO   4'h0
`define SBC_CNT_LAST   4'h7

`endif

// File: sbc_pkg.sv
// types shared by the serial bus control block
`default_nettype none
package sbc_pkg;
   // start and stop condition sequencer states
   typedef enum logic [4:0] {
      SBC_IDLE = 5'h01,
      SBC_ST_A = 5'h02,
      SBC_ST_B = 5'h04,
      SBC_SP_A = 5'h08,
      SBC_SP_B = 5'h10
   } sbc_cond_t;
endpackage : sbc_pkg
`default_nettype wire

// File: sbc_link_if.sv
// interface between the control block and its 8-bit shift engine
`timescale 1ns/1ps
`default_nettype none
interface sbc_link_if;
   logic       load;
   logic [7:0] tx;
   logic       rise;
   logic       sdi;
   logic [7:0] rx;
   logic       done;
   logic       busy;
   logic       sdo;
   modport ctl (output load, output tx, output rise, output sdi,
                input rx, input done, input busy, input sdo);
   modport eng (input load, input tx, input rise, input sdi,
                output rx, output done, output busy, output sdo);
endinterface : sbc_link_if
`default_nettype wire

// File: sbc_shifter.sv
// 8-bit shift engine of the clocked serial port
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_shifter
   import sbc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   sbc_link_if.eng  lnk
);
   logic [7:0]            sh_q,   sh_d;
   logic [7:0]            rx_q,   rx_d;
   logic [`SBC_CNT_W-1:0] cnt_q,  cnt_d;
   logic                  busy_q, busy_d;
   logic                  done_q, done_d;

   ////////////////////////////////////////////////////////////////////////
   // load a byte, then shift one bit in on every rising serial clock edge
   always_comb begin
      sh_d   = sh_q;
      rx_d   = rx_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      done_d = 1'b0;
      if (lnk.load) begin
         sh_d   = lnk.tx;
         cnt_d  = `SBC_CNT_ZERO;
         busy_d = 1'b1;
      end else if (busy_q && lnk.rise) begin
         sh_d  = {sh_q[6:0], lnk.sdi};
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == `SBC_CNT_LAST) begin // 8-bit unit complete
            busy_d = 1'b0;
            done_d = 1'b1;
            rx_d   = {sh_q[6:0], lnk.sdi};
         end
      end
   end

   // shift state registers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sh_q   <= `SBC_BYTE_RST;
         rx_q   <= `SBC_BYTE_RST;
         cnt_q  <= `SBC_CNT_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         rx_q   <= rx_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   // msb first on the data line
   assign lnk.sdo  = sh_q[7];
   assign lnk.rx   = rx_q;
   assign lnk.done = done_q;
   assign lnk.busy = busy_q;
endmodule : sbc_shifter
`default_nettype wire

// File: sbc_top.sv
// serial bus control block: apb registers, start/stop sequencer, clocked serial port
// Summary of operation
// - role bit: 0 slave, 1 master
// - direction bit: 0 receiver, 1 transmitter
// - writing busy bit 0 with role, direction and cancel bits 1 generates stop, except in port mode
// - writing busy bit 1 with role, direction and cancel bits 1 generates start, except in port mode
// - cancel bit 1 withdraws pending request
// - mode 00: port mode, outputs disabled
// - mode 01: clocked serial, 8-bit units
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_top
   import sbc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output var  logic [31:0] o_prdata,
   output var  logic        o_pready,
   output var  logic        o_pslverr,
   input  wire logic        i_scl,
   output var  logic        o_scl,
   output var  logic        o_scl_oe,
   input  wire logic        i_sda,
   output var  logic        o_sda,
   output var  logic        o_sda_oe,
   output var  logic        o_irq
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   sbc_link_if lnk ();

   logic [1:0]            sync1_q;
   logic [1:0]            sync2_q;
   logic                  scl_prev_q;
   logic                  role_q,    role_d;
   logic                  dir_q,     dir_d;
   logic [1:0]            mode_q,    mode_d;
   logic [1:0]            srst_q,    srst_d;
   logic                  pend_q,    pend_d;
   logic [`SBC_EV_W-1:0]  stat_q,    stat_d;
   logic [`SBC_EV_W-1:0]  mask_q,    mask_d;
   logic [`SBC_DIV_W-1:0] div_q,     div_d;
   sbc_cond_t             cond_q,    cond_d;
   logic                  busy_q,    busy_d;
   logic                  scl_lo_q,  scl_lo_d;
   logic                  sda_lo_q,  sda_lo_d;
   logic                  sclk_q,    sclk_d;
   logic [31:0]           rdata_q,   rdata_d;
   logic                  pscl_q,    pscl_d;
   logic                  pscl_oe_q, pscl_oe_d;
   logic                  psda_q,    psda_d;
   logic                  psda_oe_q, psda_oe_d;
   logic                  wr_acc;
   logic                  ctrl_wr;
   logic                  data_wr;
   logic                  stat_wr;
   logic                  mask_wr;
   logic                  cmd_ok;
   logic                  start_req;
   logic                  stop_req;
   logic                  cancel;
   logic                  tick;
   logic                  ev_start;
   logic                  ev_stop;
   logic [`SBC_EV_W-1:0]  ev;
   logic                  sio_mode;
   logic                  ext_rise;
   logic                  own_rise;

   ////////////////////////////////////////////////////////////////////////
   // address decode, used for every register
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction : hit

   function automatic logic mapped(input logic [11:0] addr);
      return hit(addr, `SBC_OFF_CTRL) || hit(addr, `SBC_OFF_DATA)
          || hit(addr, `SBC_OFF_STAT) || hit(addr, `SBC_OFF_MASK);
   endfunction : mapped

   // write strobes, effective in the access phase only
   assign wr_acc  = i_psel && i_penable && i_pwrite && mapped(i_paddr);
   assign ctrl_wr = wr_acc && hit(i_paddr, `SBC_OFF_CTRL);
   assign data_wr = wr_acc && hit(i_paddr, `SBC_OFF_DATA);
   assign stat_wr = wr_acc && hit(i_paddr, `SBC_OFF_STAT);
   assign mask_wr = wr_acc && hit(i_paddr, `SBC_OFF_MASK);

   // zero wait state slave; unmapped addresses answer with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage feeds only the second stage
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q    <= 2'h3;
         sync2_q    <= 2'h3;
         scl_prev_q <= 1'b1;
      end else begin
         sync1_q    <= {i_sda, i_scl};
         sync2_q    <= sync1_q;
         scl_prev_q <= sync2_q[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control command decode
   assign cmd_ok    = i_pwdata[`SBC_B_ROLE] && i_pwdata[`SBC_B_DIR]
                   && i_pwdata[`SBC_B_CANCEL];
   assign start_req = ctrl_wr && cmd_ok && i_pwdata[`SBC_B_BUSY]
                   && (i_pwdata[`SBC_B_MODE_HI:`SBC_B_MODE_LO] != `SBC_MODE_PORT);
   assign stop_req  = ctrl_wr && cmd_ok && !i_pwdata[`SBC_B_BUSY]
                   && (i_pwdata[`SBC_B_MODE_HI:`SBC_B_MODE_LO] != `SBC_MODE_PORT);
   assign cancel    = ctrl_wr && i_pwdata[`SBC_B_CANCEL];
   assign sio_mode  = (mode_q == `SBC_MODE_SIO);

   // control fields, pending request, status and mask
   always_comb begin
      role_d = role_q;
      dir_d  = dir_q;
      mode_d = mode_q;
      srst_d = srst_q;
      mask_d = mask_q;
      if (ctrl_wr) begin
         role_d = i_pwdata[`SBC_B_ROLE];
         dir_d  = i_pwdata[`SBC_B_DIR];
         mode_d = i_pwdata[`SBC_B_MODE_HI:`SBC_B_MODE_LO];
         srst_d = i_pwdata[`SBC_B_SRST_HI:`SBC_B_SRST_LO];
      end
      if (mask_wr) begin
         mask_d = i_pwdata[`SBC_EV_W-1:0];
      end
      // a new event wins over a cancel or a clear in the same cycle
      pend_d = (pend_q && !cancel) || (|ev);
      stat_d = (stat_q & ~(stat_wr ? i_pwdata[`SBC_EV_W-1:0] : `SBC_EV_RST)) | ev;
   end

   // register storage
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         role_q <= 1'b0;
         dir_q  <= 1'b0;
         mode_q <= `SBC_MODE_RST;
         srst_q <= `SBC_SRST_RST;
         pend_q <= 1'b0;
         stat_q <= `SBC_EV_RST;
         mask_q <= `SBC_EV_RST;
      end else begin
         role_q <= role_d;
         dir_q  <= dir_d;
         mode_q <= mode_d;
         srst_q <= srst_d;
         pend_q <= pend_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   // events of this block
   always_comb begin
      ev                = `SBC_EV_RST;
      ev[`SBC_EV_XFER]  = lnk.done;
      ev[`SBC_EV_START] = ev_start;
      ev[`SBC_EV_STOP]  = ev_stop;
   end

   // level interrupt while an unmasked status bit is set
   assign o_irq = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////
   // half period divider of the generated serial clock
   always_comb begin
      tick  = (div_q == `SBC_DIV_LAST);
      div_d = tick ? `SBC_DIV_ZERO : div_q + 1'b1;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= `SBC_DIV_ZERO;
      end else begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start and stop condition sequencer, one divider tick per step
   always_comb begin
      cond_d   = cond_q;
      busy_d   = busy_q;
      scl_lo_d = scl_lo_q;
      sda_lo_d = sda_lo_q;
      ev_start = 1'b0;
      ev_stop  = 1'b0;
      unique case (cond_q)
         SBC_IDLE: begin
            if (start_req) begin
               cond_d   = SBC_ST_A;
               scl_lo_d = 1'b0;
               sda_lo_d = 1'b0;
            end else if (stop_req) begin
               cond_d   = SBC_SP_A;
               scl_lo_d = 1'b0;
               sda_lo_d = 1'b1;
            end
         end
         SBC_ST_A: begin
            // data falls while the clock stays released
            if (tick) begin
               cond_d   = SBC_ST_B;
               sda_lo_d = 1'b1;
            end
         end
         SBC_ST_B: begin
            if (tick) begin
               cond_d   = SBC_IDLE;
               scl_lo_d = 1'b1;
               busy_d   = 1'b1;
               ev_start = 1'b1;
            end
         end
         SBC_SP_A: begin
            // data rises while the clock stays released
            if (tick) begin
               cond_d   = SBC_SP_B;
               sda_lo_d = 1'b0;
            end
         end
         SBC_SP_B: begin
            if (tick) begin
               cond_d  = SBC_IDLE;
               busy_d  = 1'b0;
               ev_stop = 1'b1;
            end
         end
         default: begin
            cond_d = SBC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cond_q   <= SBC_IDLE;
         busy_q   <= 1'b0;
         scl_lo_q <= 1'b0;
         sda_lo_q <= 1'b0;
      end else begin
         cond_q   <= cond_d;
         busy_q   <= busy_d;
         scl_lo_q <= scl_lo_d;
         sda_lo_q <= sda_lo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clocked serial port: master makes the clock, slave samples it
   assign ext_rise = sync2_q[0] && !scl_prev_q;
   assign own_rise = tick && !sclk_q && lnk.busy;

   always_comb begin
      sclk_d = sclk_q;
      if (role_q && lnk.busy && tick) begin
         sclk_d = !sclk_q;
      end else if (!lnk.busy) begin
         sclk_d = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_q <= 1'b1;
      end else begin
         sclk_q <= sclk_d;
      end
   end

   // a data write in serial mode starts one 8-bit unit when no unit is in progress
   assign lnk.load = data_wr && sio_mode && !lnk.busy;
   assign lnk.tx   = i_pwdata[7:0];
   assign lnk.rise = sio_mode && (role_q ? own_rise : ext_rise);
   assign lnk.sdi  = sync2_q[1];

   sbc_shifter u_shifter (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .lnk     (lnk)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin drivers: port mode releases both lines
   always_comb begin
      pscl_d    = 1'b0;
      pscl_oe_d = 1'b0;
      psda_d    = 1'b0;
      psda_oe_d = 1'b0;
      if (mode_q == `SBC_MODE_PORT) begin
         pscl_oe_d = 1'b0;
         psda_oe_d = 1'b0;
      end else if (sio_mode) begin
         pscl_d    = sclk_q;
         pscl_oe_d = role_q;
         psda_d    = lnk.sdo;
         psda_oe_d = dir_q;
      end else begin
         // open drain: enable only while pulling low
         pscl_oe_d = scl_lo_q;
         psda_oe_d = sda_lo_q;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pscl_q    <= 1'b0;
         pscl_oe_q <= 1'b0;
         psda_q    <= 1'b0;
         psda_oe_q <= 1'b0;
      end else begin
         pscl_q    <= pscl_d;
         pscl_oe_q <= pscl_oe_d;
         psda_q    <= psda_d;
         psda_oe_q <= psda_oe_d;
      end
   end

   assign o_scl    = pscl_q;
   assign o_scl_oe = pscl_oe_q;
   assign o_sda    = psda_q;
   assign o_sda_oe = psda_oe_q;

   ////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase
   always_comb begin
      rdata_d = rdata_q;
      if (i_psel && !i_penable) begin
         rdata_d = 32'h0000_0000;
         if (hit(i_paddr, `SBC_OFF_CTRL)) begin
            rdata_d[`SBC_B_ROLE]                  = role_q;
            rdata_d[`SBC_B_DIR]                   = dir_q;
            rdata_d[`SBC_B_BUSY]                  = busy_q;
            rdata_d[`SBC_B_CANCEL]                = !pend_q;         // reads 1 when nothing pending
            rdata_d[`SBC_B_MODE_HI:`SBC_B_MODE_LO] = mode_q;
            rdata_d[`SBC_B_SRST_HI:`SBC_B_SRST_LO] = srst_q;
         end else if (hit(i_paddr, `SBC_OFF_DATA)) begin
            rdata_d[7:0] = lnk.rx;
         end else if (hit(i_paddr, `SBC_OFF_STAT)) begin
            rdata_d[`SBC_EV_W-1:0] = stat_q;
         end else if (hit(i_paddr, `SBC_OFF_MASK)) begin
            rdata_d[`SBC_EV_W-1:0] = mask_q;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_prdata = rdata_q;
endmodule : sbc_top
`default_nettype wire

// File: sbc_top_assertions.sv
// concurrent checks on the ports of the serial bus control block
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_top_assertions (
   input wire logic        i_mclk,
   input wire logic        i_rst_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_scl,
   input wire logic        o_scl,
   input wire logic        o_scl_oe,
   input wire logic        i_sda,
   input wire logic        o_sda,
   input wire logic        o_sda_oe,
   input wire logic        o_irq
);
   logic       acc;
   logic       wr_ctrl;
   logic       mapped;
   logic [1:0] mode_d;
   logic [1:0] mode_q;
   logic [1:0] mode_p;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   // decode of the apb request
   assign acc     = i_psel & i_penable;
   assign wr_ctrl = acc & i_pwrite & (i_paddr == `SBC_OFF_CTRL);
   assign mapped  = (i_paddr == `SBC_OFF_CTRL) | (i_paddr == `SBC_OFF_DATA) |
                    (i_paddr == `SBC_OFF_STAT) | (i_paddr == `SBC_OFF_MASK);
   // mode field as last written, and one cycle older since pins lag
   always_comb begin
      mode_d = wr_ctrl ? i_pwdata[3:2] : mode_q;
   end
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= 2'h0;
         mode_p <= 2'h0;
      end else begin
         mode_q <= mode_d;
         mode_p <= mode_q;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_pready_high: assert property (acc |-> o_pready)
      else $error("pready low in access phase");
   a_bad_addr_err: assert property (acc |-> (o_pslverr == !mapped))
      else $error("slave error does not match address map");
   a_mask_zero_irq: assert property (acc && i_pwrite && i_paddr == `SBC_OFF_MASK && i_pwdata[2:0] == 3'h0 |=> !o_irq)
      else $error("irq high with all events masked");
   a_port_quiet:
      assert property (mode_q == 2'h0 && mode_p == 2'h0 |-> !o_scl_oe && !o_sda_oe)
      else $error("pin driven in port mode");
   a_start_seq:
      assert property (wr_ctrl && i_pwdata[7:2] == 6'h3E |-> ##[1:10] o_sda_oe ##[1:10] o_scl_oe)
      else $error("start condition not driven");
   a_stop_release:
      assert property (wr_ctrl && i_pwdata[7:2] == 6'h36 |-> ##[1:24] (!o_scl_oe && !o_sda_oe))
      else $error("stop condition did not release the bus");
   a_partial_quiet:
      assert property (wr_ctrl && i_pwdata[3:2] == 2'h2 && !(i_pwdata[7] && i_pwdata[6] && i_pwdata[4])
         && !o_scl_oe && !o_sda_oe |=> (!o_scl_oe && !o_sda_oe) [*6])
      else $error("bus condition without full key");
   a_role_master:
      assert property (wr_ctrl && i_pwdata[3:2] == 2'h1 && i_pwdata[7] |-> ##[1:3] o_scl_oe)
      else $error("master does not drive serial clock");
   a_role_slave:
      assert property (wr_ctrl && i_pwdata[3:2] == 2'h1 && !i_pwdata[7] |-> ##[1:3] !o_scl_oe)
      else $error("slave drives serial clock");
   a_dir_drive:
      assert property (wr_ctrl && i_pwdata[3:2] == 2'h1 && i_pwdata[6] |-> ##[1:3] o_sda_oe)
      else $error("transmitter does not drive data");
   c_start: cover property (wr_ctrl && i_pwdata[7:2] == 6'h3E);
   c_stop: cover property (wr_ctrl && i_pwdata[7:2] == 6'h36);
   c_irq: cover property ($rose(o_irq));
endmodule : sbc_top_assertions
bind sbc_top sbc_top_assertions u_sbc_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .o_irq(o_irq));
`default_nettype wire

// File: sbc_partner.sv
// far-side serial peripheral: shifts a byte out and in, makes the link clock when asked
`timescale 1ns/1ps
`default_nettype none
module sbc_partner (
   input  wire logic       i_go,
   input  wire logic       i_gen_clk,
   input  wire logic [7:0] i_byte,
   input  wire logic       i_scl_w,
   input  wire logic       i_sda_w,
   output var  logic       o_scl,
   output var  logic       o_sda,
   output var  logic [7:0] o_rx
);
   logic busy;
   // data line as it stood just before each rising clock of a frame
   always @(posedge i_scl_w)
      if (busy) o_rx <= {o_rx[6:0], i_sda_w};
   // one frame of eight bits, msb first; clock and data released outside it
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      busy = 1'b0;
      forever begin
         @(posedge i_go);
         busy = 1'b1;
         for (int i = 7; i >= 0; i--) begin
            if (i_gen_clk) o_scl = 1'b0;
            o_sda = i_byte[i];
            if (i_gen_clk) #62.5 o_scl = 1'b1;
            if (!i_gen_clk) @(posedge i_scl_w);
            if (i_gen_clk || i == 0) #62.5;
            else @(negedge i_scl_w);
         end
         busy = 1'b0;
         o_sda = 1'b1; // released to the pull-up level
      end
   end
endmodule : sbc_partner
`default_nettype wire

// File: tb_sbc_top.sv
// self-checking bench of the serial bus control block
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"
module tb_sbc_top;
   logic        mclk = 1'b0;
   logic        rst_n, psel, penable, pwrite, go, gen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, p_scl, p_sda;
   logic [7:0]  p_byte, p_rx, cfg, tx, pb, ex;
   int          err_total, compares, m_hi, m_lo, m_busy, m_pend, m_stat;
   int          exp_q[$];
   wire         scl_w = (scl_oe ? scl_o : 1'b1) & p_scl;
   wire         sda_w = (sda_oe ? sda_o : 1'b1) & p_sda;
   wire         sda_late;
   assign #2 sda_late = sda_w;
   always #4 mclk = ~mclk;
   sbc_top DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe),
      .o_irq(irq));
   sbc_partner u_far (.i_go(go), .i_gen_clk(gen), .i_byte(p_byte), .i_scl_w(scl_w), .i_sda_w(sda_late),
      .o_scl(p_scl), .o_sda(p_sda), .o_rx(p_rx));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) err_total++;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check({31'h0, e}, {31'h0, experr});
   endtask : rd
   // control write plus the reference model of its fields
   task automatic ctrl(input logic [7:0] d);
      wr(`SBC_OFF_CTRL, {24'h0, d});
      m_hi = d[7:6];
      m_lo = d[3:0];
      if (d[4]) m_pend = 0;
      if (d[7] & d[6] & d[4] & (d[3:2] != 2'h0)) begin
         m_busy = d[5];
         m_stat = m_stat | (d[5] ? 2 : 4);
         m_pend = 1;
      end
   endtask : ctrl
   function automatic logic [31:0] m_ctrl();
      return {24'h0, m_hi[1:0], m_busy[0], ~m_pend[0], m_lo[3:0]};
   endfunction : m_ctrl
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      check(irq, 1);
   endtask : wait_irq
   task print_verdict;
      $display("counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      go = 1'b0;
      gen = 1'b0;
      p_byte = 8'hFF;
      void'($urandom(32'h2248));
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      rd(`SBC_OFF_STAT, 32'h0, 1'b0);
      wr(12'h010, 32'hFF);
      rd(12'h010, 32'h0, 1'b1);
      $display("test reset and map done");
      // random fields in port mode and in bus mode without the full key
      for (int i = 0; i < 8; i++) begin
         ctrl(8'($urandom) & 8'hE3 | (i[0] ? 8'h08 : 8'h00));
         rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      end
      $display("test field writes done");
      wr(`SBC_OFF_MASK, 32'h6);
      ctrl(8'hF8);
      wait_irq;
      rd(`SBC_OFF_STAT, m_stat, 1'b0);
      rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      check({scl_oe, scl_o}, 2'b10);
      ctrl(8'h98);
      rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      wr(`SBC_OFF_STAT, 32'h7);
      m_stat = 0;
      @(negedge mclk);
      check(irq, 0);
      ctrl(8'hD8);
      wait_irq;
      rd(`SBC_OFF_STAT, m_stat, 1'b0);
      check({scl_oe, sda_oe}, 2'b00);
      ctrl(8'hC8);
      rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      wr(`SBC_OFF_STAT, 32'h7);
      m_stat = 0;
      $display("test start and stop done");
      // master transmit, master receive, slave receive
      wr(`SBC_OFF_MASK, 32'h1);
      for (int k = 0; k < 3; k++) begin
         cfg = (k == 0) ? 8'hC4 : (k == 1) ? 8'h84 : 8'h04;
         tx = 8'($urandom);
         pb = cfg[6] ? 8'hFF : 8'($urandom);
         exp_q.push_back((cfg[6] ? tx : 8'hFF) & pb);
         ctrl(cfg);
         p_byte <= pb;
         gen <= ~cfg[7];
         go <= 1'b1;
         wr(`SBC_OFF_DATA, {24'h0, tx});
         go <= 1'b0;
         wait_irq;
         m_stat = 1;
         rd(`SBC_OFF_STAT, m_stat, 1'b0);
         ex = 8'(exp_q.pop_front());
         rd(`SBC_OFF_DATA, {24'h0, ex}, 1'b0);
         check(p_rx, ex);
         // masking the still set event must drop the interrupt
         if (k == 2) begin
            wr(`SBC_OFF_MASK, 32'h0);
            @(negedge mclk);
            check(irq, 0);
         end
         wr(`SBC_OFF_STAT, 32'h7);
         m_stat = 0;
      end
      $display("test serial port done");
      // port mode must release the pins that serial mode was driving
      ctrl(8'hC4);
      ctrl(8'hC0);
      rd(`SBC_OFF_CTRL, m_ctrl(), 1'b0);
      check({scl_oe, sda_oe}, 2'b00);
      $display("test port mode done");
      print_verdict;
   end
   // watchdog against a hang
   initial begin
      #200000;
      err_total++;
      print_verdict;
   end
endmodule : tb_sbc_top
`default_nettype wire
